// ### hw/rsc_pkg.sv
// Purpose: constants shared by the reset source control block
// Assumes: 32-bit avalon-mm register bus, byte addressed, 25 mhz clock
// Notes:   offsets are byte addresses of aligned words
package rsc_pkg;

  // register offsets
  localparam logic [5:0] RSC_OFF_CAUSE   = 6'h00;
  localparam logic [5:0] RSC_OFF_BOR_CTL = 6'h04;
  localparam logic [5:0] RSC_OFF_CORE    = 6'h08;
  localparam logic [5:0] RSC_OFF_WDOG    = 6'h0c;
  localparam logic [5:0] RSC_OFF_IRQ_STS = 6'h10;
  localparam logic [5:0] RSC_OFF_IRQ_MSK = 6'h14;
  localparam logic [5:0] RSC_OFF_PRST0   = 6'h20;
  localparam int         RSC_NUM_PRST    = 3;

  // reset cause fields
  localparam int RSC_CAUSE_EXT  = 0;
  localparam int RSC_CAUSE_POR  = 1;
  localparam int RSC_CAUSE_BOR  = 2;
  localparam int RSC_CAUSE_WDOG = 3;
  localparam int RSC_CAUSE_SW   = 4;
  localparam int RSC_CAUSE_W    = 5;
  localparam logic [4:0] RSC_CAUSE_RST = 5'h02;

  // control fields
  localparam int RSC_BOR_EN_BIT  = 1;
  localparam int RSC_SYSREQ_BIT  = 2;
  localparam int RSC_WDOG_EN_BIT = 0;

  // interrupt status fields
  localparam int RSC_IRQ_BOR   = 0;
  localparam int RSC_IRQ_WDOG1 = 1;
  localparam int RSC_IRQ_STRAP = 2;
  localparam int RSC_IRQ_W     = 3;

  // timing: internal reset pulse from software or watchdog
  localparam int RSC_CLK_NS       = 40;
  localparam int RSC_RST_HOLD_NS  = 200;
  localparam int RSC_RST_HOLD_CYC = (RSC_RST_HOLD_NS + RSC_CLK_NS - 1) / RSC_CLK_NS;

  // reset pulse states
  typedef enum logic [1:0] {
    RSC_PULSE_IDLE = 2'b01,
    RSC_PULSE_HOLD = 2'b10
  } rsc_pulse_t;

endpackage : rsc_pkg

// ### hw/rsc_rst_sync.sv
// Purpose: asynchronous assert, synchronous release reset
// Assumes: arst_n may fall at any time
// Notes:   two flops keep release away from metastability
module rsc_rst_sync
  import rsc_pkg::*;
(
  // clock and reset request
  input  wire logic clk,
  input  wire logic arst_n,
  // synchronised reset
  output logic      rst_n
);

  logic meta_q;
  logic hold_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      hold_q <= meta_q;
    end
  end

  assign rst_n = hold_q;

endmodule : rsc_rst_sync

// ### hw/rsc_reset_ctrl.sv
// Purpose: merges reset sources into core, tap and peripheral resets
// Assumes: nrst is the power-on detector output, low only at power-up
// Notes:   registers live on nrst alone so causes survive software, watchdog and brown-out resets
//
// The placing of the registers and the Avalon-MM register port were decided locally.
module rsc_reset_ctrl
  import rsc_pkg::*;
(
  // clock and power-on reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // reset sources
  input  wire logic        ext_rst_pin_n,
  input  wire logic        brownout_detect,
  input  wire logic        wdog_timeout,
  input  wire logic        wdog_service,
  input  wire logic        test_mode_strap_0,
  input  wire logic        test_mode_strap_1,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // reset outputs
  output logic             core_rst_n,
  output logic             tap_rst_n,
  output logic             tap_pin_cfg_rst_n,
  output logic [95:0]      periph_rst_n,
  // interrupt
  output logic             irq
);

  // byte lane merge, used for every writable register except cause and core, which look at byteenable[0] only
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // pin and detector synchronisers
  logic       ext_m_q;
  logic       ext_s_q;
  logic       ext_d_q;
  logic       bor_m_q;
  logic       bor_s_q;
  logic       bor_d_q;
  logic [1:0] strap_m_q;
  logic [1:0] strap_s_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_m_q   <= 1'b1;
      ext_s_q   <= 1'b1;
      ext_d_q   <= 1'b1;
      bor_m_q   <= 1'b0;
      bor_s_q   <= 1'b0;
      bor_d_q   <= 1'b0;
      strap_m_q <= 2'h0;
      strap_s_q <= 2'h0;
    end else begin
      ext_m_q   <= ext_rst_pin_n;
      ext_s_q   <= ext_m_q;
      ext_d_q   <= ext_s_q;
      bor_m_q   <= brownout_detect;
      bor_s_q   <= bor_m_q;
      bor_d_q   <= bor_s_q;
      strap_m_q <= {test_mode_strap_1, test_mode_strap_0};
      strap_s_q <= strap_m_q;
    end
  end

  logic ext_fall;
  logic bor_rise;
  assign ext_fall = ext_d_q & ~ext_s_q;
  assign bor_rise = bor_s_q & ~bor_d_q;

  // bus handshake: one wait cycle, answer on the second edge
  logic ack_q;
  logic req;
  logic wr_go;
  logic rd_go;
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_go           = avs_write & ack_q;
  assign rd_go           = avs_read & ack_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // control registers
  logic [31:0]         bor_ctl_q;
  logic [31:0]         wdog_ctl_q;
  logic [31:0]         prst_q [RSC_NUM_PRST];
  logic [RSC_IRQ_W-1:0] irq_msk_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bor_ctl_q  <= 32'h0000_0000;
      wdog_ctl_q <= 32'h0000_0000;
      irq_msk_q  <= 3'h0;
    end else if (wr_go) begin
      if (avs_address == RSC_OFF_BOR_CTL) begin
        bor_ctl_q <= be_merge(bor_ctl_q, avs_writedata, avs_byteenable)
                     & (32'h1 << RSC_BOR_EN_BIT);
      end
      if (avs_address == RSC_OFF_WDOG) begin
        wdog_ctl_q <= be_merge(wdog_ctl_q, avs_writedata, avs_byteenable)
                      & (32'h1 << RSC_WDOG_EN_BIT);
      end
      if (avs_address == RSC_OFF_IRQ_MSK) begin
        irq_msk_q <= RSC_IRQ_W'(be_merge({29'h0, irq_msk_q}, avs_writedata,
                                         avs_byteenable));
      end
    end
  end

  // peripheral reset control words, one per register
  for (genvar g = 0; g < RSC_NUM_PRST; g++) begin : g_prst
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        prst_q[g] <= 32'h0000_0000;
      end else if (wr_go && avs_address == RSC_OFF_PRST0 + 6'(4 * g)) begin
        prst_q[g] <= be_merge(prst_q[g], avs_writedata, avs_byteenable);
      end
    end
  end

  logic bor_en;
  logic wdog_en;
  assign bor_en  = bor_ctl_q[RSC_BOR_EN_BIT];
  assign wdog_en = wdog_ctl_q[RSC_WDOG_EN_BIT];

  // watchdog second time-out detection
  logic wdog_first_q;
  logic wdog_fire;
  assign wdog_fire = wdog_timeout & wdog_first_q & wdog_en;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdog_first_q <= 1'b0;
    end else if (wdog_fire) begin
      wdog_first_q <= 1'b0;
    end else if (wdog_timeout) begin
      wdog_first_q <= 1'b1;
    end else if (wdog_service) begin
      wdog_first_q <= 1'b0;
    end
  end

  // software system request, self clearing
  logic sw_req;
  assign sw_req = wr_go && avs_address == RSC_OFF_CORE && avs_byteenable[0]
                  && avs_writedata[RSC_SYSREQ_BIT];

  // internal reset pulse for software and watchdog requests
  rsc_pulse_t pulse_q;
  logic [7:0] hold_cnt_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_q    <= RSC_PULSE_IDLE;
      hold_cnt_q <= 8'h00;
    end else begin
      case (pulse_q)
        RSC_PULSE_IDLE: begin
          if (sw_req || wdog_fire) begin
            pulse_q    <= RSC_PULSE_HOLD;
            hold_cnt_q <= 8'(RSC_RST_HOLD_CYC - 1);
          end
        end
        RSC_PULSE_HOLD: begin
          if (hold_cnt_q == 8'h00) begin
            pulse_q <= RSC_PULSE_IDLE;
          end else begin
            hold_cnt_q <= hold_cnt_q - 8'h01;
          end
        end
        default: begin
          pulse_q <= RSC_PULSE_IDLE;
        end
      endcase
    end
  end

  // merged system reset: any source asserts at once
  logic sys_arst_n;
  logic tap_cfg_arst_n;
  logic sys_rst_n;
  assign sys_arst_n = nrst & ext_rst_pin_n & ~(brownout_detect & bor_en)
                      & (pulse_q != RSC_PULSE_HOLD);
  assign tap_cfg_arst_n = nrst & ext_rst_pin_n;

  rsc_rst_sync u_sys_sync (
    .clk    (clk),
    .arst_n (sys_arst_n),
    .rst_n  (sys_rst_n)
  );

  rsc_rst_sync u_tap_sync (
    .clk    (clk),
    .arst_n (nrst),
    .rst_n  (tap_rst_n)
  );

  rsc_rst_sync u_tap_cfg_sync (
    .clk    (clk),
    .arst_n (tap_cfg_arst_n),
    .rst_n  (tap_pin_cfg_rst_n)
  );

  // core follows the merged reset only; peripheral bits never touch it
  assign core_rst_n = sys_rst_n;

  logic [95:0] periph_q;
  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      periph_q <= 96'h0;
    end else begin
      periph_q <= ~{prst_q[2], prst_q[1], prst_q[0]};
    end
  end
  assign periph_rst_n = periph_q;

  // sticky reset causes, but a pin reset leaves only its own flag; power-on value holds only the power-on flag
  logic [RSC_CAUSE_W-1:0] cause_q;
  logic [RSC_CAUSE_W-1:0] cause_set;
  logic [RSC_CAUSE_W-1:0] cause_clr;

  always_comb begin
    cause_set                 = '0;
    cause_set[RSC_CAUSE_EXT]  = ext_fall;
    cause_set[RSC_CAUSE_BOR]  = bor_s_q & bor_en;
    cause_set[RSC_CAUSE_WDOG] = wdog_fire;
    cause_set[RSC_CAUSE_SW]   = sw_req;
    cause_clr = '0;
    if (wr_go && avs_address == RSC_OFF_CAUSE && avs_byteenable[0]) begin
      cause_clr = avs_writedata[RSC_CAUSE_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cause_q <= RSC_CAUSE_RST;
    end else if (ext_fall) begin
      cause_q <= 5'h01 << RSC_CAUSE_EXT;
    end else begin
      cause_q <= (cause_q & ~cause_clr) | cause_set;
    end
  end

  // interrupt status, cleared by reading, a new event wins
  logic [RSC_IRQ_W-1:0] irq_sts_q;
  logic [RSC_IRQ_W-1:0] irq_set;
  logic                 sts_rd;
  assign irq_set = {|strap_s_q, wdog_timeout & ~wdog_first_q, bor_rise};
  assign sts_rd  = rd_go && avs_address == RSC_OFF_IRQ_STS;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_sts_q <= 3'h0;
    end else if (sts_rd) begin
      irq_sts_q <= irq_set;
    end else begin
      irq_sts_q <= irq_sts_q | irq_set;
    end
  end

  assign irq = |(irq_sts_q & irq_msk_q);

  // read data, registered on the edge that raises the answer
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      RSC_OFF_CAUSE:   rd_mux = {27'h0, cause_q};
      RSC_OFF_BOR_CTL: rd_mux = bor_ctl_q;
      RSC_OFF_CORE:    rd_mux = 32'h0000_0000;
      RSC_OFF_WDOG:    rd_mux = wdog_ctl_q;
      RSC_OFF_IRQ_STS: rd_mux = {29'h0, irq_sts_q};
      RSC_OFF_IRQ_MSK: rd_mux = {29'h0, irq_msk_q};
      RSC_OFF_PRST0:           rd_mux = prst_q[0];
      RSC_OFF_PRST0 + 6'h04:   rd_mux = prst_q[1];
      RSC_OFF_PRST0 + 6'h08:   rd_mux = prst_q[2];
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= rd_mux;
    end
  end

endmodule : rsc_reset_ctrl

// ### tb/rsc_reset_ctrl_properties.sv
// Purpose: port properties of the reset controller
// Assumes: one clock, quiet while nrst is low
// Notes:   bound to the design at the foot
module rsc_reset_ctrl_chk
  import rsc_pkg::*;
(
  // clock and power-on reset
  input wire logic        clk,
  input wire logic        nrst,
  // sources and bus
  input wire logic        ext_rst_pin_n,
  input wire logic        brownout_detect,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  // resets
  input wire logic        core_rst_n,
  input wire logic        tap_rst_n,
  input wire logic        tap_pin_cfg_rst_n,
  input wire logic [95:0] periph_rst_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // two-flop release after the source clears
  sequence s_release;
    !core_rst_n ##1 !core_rst_n ##1 core_rst_n;
  endsequence
  sequence s_sw_hold;
    (!core_rst_n) [*5] ##[1:6] core_rst_n;
  endsequence
  a_tap_kept: assert property (tap_rst_n |=> tap_rst_n)
    else $error("tap reset by a non power-on source");
  a_tap_core: assert property (!tap_rst_n |-> !core_rst_n)
    else $error("core free while tap in reset");
  a_pin_core: assert property (!ext_rst_pin_n |-> !core_rst_n)
    else $error("pin low but core free");
  a_pin_cfg: assert property (!ext_rst_pin_n |-> !tap_pin_cfg_rst_n)
    else $error("pin low but tap pin config free");
  a_periph_follow: assert property (!core_rst_n |-> periph_rst_n == '0)
    else $error("peripheral free during system reset");
  a_periph_late: assert property ($rose(core_rst_n) |-> periph_rst_n == '0)
    else $error("peripheral released with the core");
  a_pin_release: assert property ($rose(ext_rst_pin_n) && !brownout_detect |-> s_release)
    else $error("pin release timing wrong");
  a_sw_hold: assert property (avs_write && !avs_waitrequest && avs_address == RSC_OFF_CORE
    && avs_writedata[RSC_SYSREQ_BIT] && avs_byteenable[0] && core_rst_n |=> s_sw_hold)
    else $error("software reset pulse wrong");
endmodule : rsc_reset_ctrl_chk

bind rsc_reset_ctrl rsc_reset_ctrl_chk i_chk (.clk, .nrst, .ext_rst_pin_n, .brownout_detect,
  .avs_address, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .core_rst_n,
  .tap_rst_n, .tap_pin_cfg_rst_n, .periph_rst_n);

// ### tb/rsc_core_model.sv
// Purpose: core side, boot fetch after reset release
// Assumes: fetch of sp, pc, first instruction, one cycle each
// Notes:   boots counts completed boot sequences since power-on
module rsc_core_model (
  // clock and resets
  input wire logic  clk,
  input wire logic  nrst,
  input wire logic  core_rst_n,
  // observed
  output logic [7:0] boots
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] fetch_q;
  // 0 sp, 1 pc, 2 instruction, 3 running
  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) fetch_q <= 2'h0;
    else if (fetch_q != 2'h3) fetch_q <= fetch_q + 2'h1;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) boots <= 8'h00;
    else if (core_rst_n && fetch_q == 2'h2) boots <= boots + 8'h01;
  end
endmodule : rsc_core_model

// ### tb/rsc_reset_ctrl_tb.sv
// Purpose: directed test of the reset controller
// Assumes: bus waits end only at the hang guard
// Notes:   straps tied low as the board must
module rsc_reset_ctrl_tb
  import rsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, nrst = 1'b0, ext_rst_pin_n = 1'b1, brownout_detect = 1'b0;
  logic wdog_timeout = 1'b0, wdog_service = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic test_mode_strap_0 = 1'b0, test_mode_strap_1 = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0]  avs_byteenable = 4'hf;
  logic avs_waitrequest, core_rst_n, tap_rst_n, tap_pin_cfg_rst_n, irq;
  logic [95:0] periph_rst_n;
  logic [7:0]  boots;
  int fails = 0, checks_done = 0;

  always #20 clk = ~clk;

  rsc_reset_ctrl i_dut (.clk, .nrst, .ext_rst_pin_n, .brownout_detect, .wdog_timeout,
    .wdog_service, .test_mode_strap_0, .test_mode_strap_1, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .core_rst_n, .tap_rst_n, .tap_pin_cfg_rst_n, .periph_rst_n, .irq);
  rsc_core_model i_core (.clk, .nrst, .core_rst_n, .boots);

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    // waitrequest and readdata sampled at the rising edge itself
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    // peripheral resets follow the register one edge later
    repeat (2) @(negedge clk);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd

  task automatic wt_core(input logic v);
    int n;
    n = 0;
    while (core_rst_n !== v && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(core_rst_n, v);
  endtask : wt_core

  // watchdog events are one-cycle pulses
  task automatic wd(input logic t, input logic s);
    @(posedge clk);
    wdog_timeout <= t;
    wdog_service <= s;
    @(posedge clk);
    wdog_timeout <= 1'b0;
    wdog_service <= 1'b0;
  endtask : wd

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(negedge clk);
    chk({tap_rst_n, core_rst_n, tap_pin_cfg_rst_n, &periph_rst_n}, 4'hf);
    rd(RSC_OFF_CAUSE, 32'h02);
    chk(boots, 8'h01);
    done("power-on");
    wr(RSC_OFF_CAUSE, 32'h1f);
    rd(RSC_OFF_CAUSE, 32'h00);
    ext_rst_pin_n <= 1'b0;
    repeat (4) @(negedge clk);
    chk({tap_rst_n, core_rst_n, tap_pin_cfg_rst_n, |periph_rst_n}, 4'h8);
    @(posedge clk);
    ext_rst_pin_n <= 1'b1;
    wt_core(1'b1);
    rd(RSC_OFF_CAUSE, 32'h01);
    done("pin");
    wr(RSC_OFF_CORE, 32'h4);
    wt_core(1'b0);
    chk(tap_rst_n, 1'b1);
    wt_core(1'b1);
    rd(RSC_OFF_CAUSE, 32'h11);
    done("software");
    wr(RSC_OFF_IRQ_MSK, 32'h0);
    @(posedge clk);
    brownout_detect <= 1'b1;
    repeat (4) @(negedge clk);
    chk({core_rst_n, irq}, 2'b10);
    wr(RSC_OFF_IRQ_MSK, 32'h1);
    chk(irq, 1'b1);
    rd(RSC_OFF_IRQ_STS, 32'h1);
    @(negedge clk);
    chk(irq, 1'b0);
    @(posedge clk);
    brownout_detect <= 1'b0;
    wr(RSC_OFF_BOR_CTL, 32'h2);
    @(posedge clk);
    brownout_detect <= 1'b1;
    wt_core(1'b0);
    @(posedge clk);
    brownout_detect <= 1'b0;
    wt_core(1'b1);
    rd(RSC_OFF_CAUSE, 32'h15);
    done("brown-out");
    wr(RSC_OFF_WDOG, 32'h1);
    wd(1'b1, 1'b0);
    wd(1'b0, 1'b1);
    wd(1'b1, 1'b0);
    repeat (4) @(negedge clk);
    chk(core_rst_n, 1'b1);
    wd(1'b1, 1'b0);
    wt_core(1'b0);
    wt_core(1'b1);
    rd(RSC_OFF_CAUSE, 32'h1d);
    rd(RSC_OFF_IRQ_STS, 32'h3);
    done("watchdog");
    wr(RSC_OFF_PRST0, 32'h1);
    chk({core_rst_n, periph_rst_n[0]}, 2'b10);
    wr(RSC_OFF_PRST0 + 6'h08, 32'h8000_0000);
    chk(periph_rst_n[95], 1'b0);
    wr(RSC_OFF_PRST0, 32'h0);
    wr(RSC_OFF_PRST0 + 6'h08, 32'h0);
    chk(periph_rst_n, {96{1'b1}});
    rd(6'h3c, 32'h0);
    done("peripheral");
    chk(boots, 8'h05);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(negedge clk);
    chk(tap_rst_n, 1'b0);
    @(posedge clk);
    nrst <= 1'b1;
    wt_core(1'b1);
    rd(RSC_OFF_CAUSE, 32'h02);
    done("second power-on");
    finish_test();
  end

  // hang guard, far beyond the roughly 130 cycles needed
  initial begin
    #160us;
    fails++;
    finish_test();
  end
endmodule : rsc_reset_ctrl_tb
